// ==== sar_adc_pkg.sv ====
// Register map, field layouts and codes for the SAR converter sequencer
package sar_adc_pkg;

  localparam int DATA_W = 16;
  localparam int ADDR_W = 8;
  localparam int RES_W = 10;
  localparam int CHAN_W = 4;
  localparam int BUF_WORDS = 16;
  localparam int DIV_W = 8;
  localparam int SAMPLE_TIME_W = 5;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] ADR_CTL1 = 8'h00;
  localparam logic [ADDR_W-1:0] ADR_CTL2 = 8'h04;
  localparam logic [ADDR_W-1:0] ADR_CTL3 = 8'h08;
  localparam logic [ADDR_W-1:0] ADR_MASK = 8'h0C;
  localparam logic [ADDR_W-1:0] ADR_CHS = 8'h10;
  localparam logic [ADDR_W-1:0] ADR_STAT = 8'h14;
  localparam logic [1:0] BUF_PAGE = 2'h1;
  localparam int PAGE_HI = 7;
  localparam int PAGE_LO = 6;
  localparam int BUF_IDX_HI = 5;
  localparam int BUF_IDX_LO = 2;

  // Writable bits per register; all others read as zero except the CTL2 fill_half_status bit
  localparam logic [DATA_W-1:0] CTL1_WMASK = 16'hA3E7;
  localparam logic [DATA_W-1:0] CTL2_WMASK = 16'hE43F;
  localparam logic [DATA_W-1:0] CTL3_WMASK = 16'h9FFF;
  localparam logic [DATA_W-1:0] CHS_WMASK = 16'h8F8F;
  localparam logic [DATA_W-1:0] MASK_WMASK = 16'h9FFF;
  localparam int FLAG_BIT = 0;

  typedef struct packed {
    logic on; logic u14; logic stop_in_idle; logic [2:0] u12; logic [1:0] result_format;
    logic [2:0] trigger_source; logic [1:0] u4; logic auto_sample_start;
    logic sample_enable; logic done;
  } ctl1_t;

  typedef struct packed {
    logic [2:0] reference_select; logic [1:0] u12; logic scan_enable; logic [1:0] u9;
    logic fill_half_status; logic u6; logic [3:0] interrupt_rate;
    logic split_buffer_mode; logic alternate_mux_mode;
  } ctl2_t;

  typedef struct packed {
    logic rc_clock_select; logic [1:0] u14; logic [SAMPLE_TIME_W-1:0] auto_sample_time;
    logic [DIV_W-1:0] conv_clock_divide;
  } ctl3_t;

  typedef struct packed {
    logic chnb; logic [2:0] u12; logic [CHAN_W-1:0] chsb;
    logic chna; logic [2:0] u4; logic [CHAN_W-1:0] chsa;
  } chs_t;

  // Result formats
  localparam logic [1:0] FMT_UINT = 2'h0;
  localparam logic [1:0] FMT_SINT = 2'h1;
  localparam logic [1:0] FMT_FRAC = 2'h2;
  localparam logic [1:0] FMT_SFRAC = 2'h3;

  // Trigger sources
  localparam logic [2:0] TRG_SW = 3'h0;
  localparam logic [2:0] TRG_PIN = 3'h1;
  localparam logic [2:0] TRG_TIMER = 3'h2;
  localparam logic [2:0] TRG_AUTO = 3'h7;

  // Reference select bits
  localparam int REF_POS_BIT = 0;
  localparam int REF_NEG_BIT = 1;
  localparam int REF_HI_BIT = 2;

  localparam logic [DIV_W-1:0] DIV_MAX = 8'h3F;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_SAMPLE = 2'h1,
    ST_CONVERT = 2'h3
  } fsm_t;

endpackage

// ==== sar_adc_tad_div.sv ====
// Conversion clock divider producing one-cycle period ticks
`timescale 1ns/1ns
module sar_adc_tad_div #(
  parameter int DIV_W = sar_adc_pkg::DIV_W
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic enable_i,
  input wire logic rc_sel_i,
  input wire logic rc_tick_i,
  input wire logic [DIV_W-1:0] divide_i,
  output logic tick_o
);
  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic tick;
  } div_st_t;

  div_st_t s_q, s_d;
  logic [DIV_W-1:0] lim;

  if (DIV_W < 7) begin : g_bad_width
    $error("divider width too small for the supported range");
  end

  always_comb
  begin
    s_d = s_q;
    s_d.tick = 1'b0;
    // Reserved codes are clamped to the longest legal period
    lim = (divide_i > DIV_W'(sar_adc_pkg::DIV_MAX)) ? DIV_W'(sar_adc_pkg::DIV_MAX) : divide_i;
    if (!enable_i)
    begin
      s_d.cnt = '0;
    end
    else if (!rc_sel_i || rc_tick_i)
    begin
      if (s_q.cnt >= lim)
      begin
        s_d.cnt = '0;
        s_d.tick = 1'b1;
      end
      else
      begin
        s_d.cnt = s_q.cnt + DIV_W'(1);
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign tick_o = s_q.tick;
endmodule

// ==== sar_adc_format.sv ====
// Places a raw conversion result into a buffer word per the format code
`timescale 1ns/1ns
module sar_adc_format (
  input wire logic [sar_adc_pkg::RES_W-1:0] raw_i,
  input wire logic [1:0] result_format_i,
  output logic [sar_adc_pkg::DATA_W-1:0] word_o
);
  localparam int PAD = sar_adc_pkg::DATA_W - sar_adc_pkg::RES_W;
  localparam int RW = sar_adc_pkg::RES_W;
  logic sgn;

  always_comb
  begin
    // Offset binary to two's complement is an inverted top bit
    sgn = ~raw_i[RW-1];
    unique case (result_format_i)
      sar_adc_pkg::FMT_UINT: word_o = {{PAD{1'b0}}, raw_i};
      sar_adc_pkg::FMT_SINT: word_o = {{PAD{sgn}}, sgn, raw_i[RW-2:0]};
      sar_adc_pkg::FMT_FRAC: word_o = {raw_i, {PAD{1'b0}}};
      sar_adc_pkg::FMT_SFRAC: word_o = {sgn, raw_i[RW-2:0], {PAD{1'b0}}};
    endcase
  end
endmodule

// ==== sar_adc_sequencer.sv ====
// Sample and conversion sequencer with registers and result buffer
//
// Our own choices: strobed register access and the address map.
`timescale 1ns/1ns
module sar_adc_sequencer #(
  parameter int BUF_WORDS = sar_adc_pkg::BUF_WORDS
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic [sar_adc_pkg::ADDR_W-1:0] addr_i,
  input wire logic [sar_adc_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [sar_adc_pkg::DATA_W-1:0] rdata_o,
  input wire logic idle_i,
  input wire logic timer_match_i,
  input wire logic ext_interrupt_zero_pin_i,
  input wire logic rc_osc_i,
  input wire logic sar_done_i,
  input wire logic [sar_adc_pkg::RES_W-1:0] sar_result_i,
  output logic sampling_o,
  output logic conv_start_o,
  output logic [sar_adc_pkg::CHAN_W-1:0] chan_sel_o,
  output logic neg_sel_o,
  output logic vref_pos_ext_o,
  output logic vref_neg_ext_o,
  output logic conv_tick_o,
  output logic conv_irq_o
);
  localparam int CW = sar_adc_pkg::CHAN_W;

  if (BUF_WORDS != 16) begin : g_bad_depth
    $error("result buffer must hold sixteen words");
  end

  typedef struct packed {
    sar_adc_pkg::ctl1_t c1;
    sar_adc_pkg::ctl2_t c2;
    sar_adc_pkg::ctl3_t c3;
    sar_adc_pkg::chs_t chs;
    logic [sar_adc_pkg::DATA_W-1:0] mask;
    logic flag;
    logic [3:0] seq;
    logic [3:0] ptr;
    logic [CW-1:0] scan_idx;
    logic alt_b;
    logic [sar_adc_pkg::SAMPLE_TIME_W-1:0] sample_time_cnt;
    sar_adc_pkg::fsm_t fsm;
    logic pin_s1;
    logic pin_s2;
    logic pin_p;
    logic rc_s1;
    logic rc_s2;
    logic rc_p;
    logic conv_start;
    logic [CW-1:0] chan;
    logic neg_sel;
    logic vref_pos;
    logic vref_neg;
    logic [sar_adc_pkg::DATA_W-1:0] rdata;
    logic [BUF_WORDS-1:0][sar_adc_pkg::DATA_W-1:0] buffer;
  } st_t;

  st_t s_q, s_d;
  logic conv_tick;
  logic rc_tick;
  logic halt;
  logic trig;
  logic pin_rise;
  logic [3:0] wr_idx;
  logic [sar_adc_pkg::DATA_W-1:0] fmt_word;

  // First set mask bit after cur, wrapping; keeps cur when mask is empty
  function automatic logic [CW-1:0] next_scan(input logic [15:0] m, input logic [CW-1:0] cur);
    logic [CW-1:0] r;
    logic hit;
    logic [CW-1:0] k;
    r = cur;
    hit = 1'b0;
    for (int i = 1; i <= 16; i++)
    begin
      k = CW'(cur + CW'(i));
      if (!hit && m[k])
      begin
        r = k;
        hit = 1'b1;
      end
    end
    return r;
  endfunction

  sar_adc_tad_div u_div (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .enable_i(s_q.c1.on),
    .rc_sel_i(s_q.c3.rc_clock_select),
    .rc_tick_i(rc_tick),
    .divide_i(s_q.c3.conv_clock_divide),
    .tick_o(conv_tick)
  );

  sar_adc_format u_fmt (
    .raw_i(sar_result_i),
    .result_format_i(s_q.c1.result_format),
    .word_o(fmt_word)
  );

  assign rc_tick = s_q.rc_s2 & ~s_q.rc_p;
  assign pin_rise = s_q.pin_s2 & ~s_q.pin_p;
  assign halt = idle_i & s_q.c1.stop_in_idle;
  // Split mode places the write in the half named by the fill status
  assign wr_idx = s_q.c2.split_buffer_mode ? {s_q.c2.fill_half_status, s_q.ptr[2:0]}
                  : s_q.ptr;

  always_comb
  begin
    s_d = s_q;
    trig = 1'b0;
    s_d.pin_s1 = ext_interrupt_zero_pin_i;
    s_d.pin_s2 = s_q.pin_s1;
    s_d.pin_p = s_q.pin_s2;
    s_d.rc_s1 = rc_osc_i;
    s_d.rc_s2 = s_q.rc_s1;
    s_d.rc_p = s_q.rc_s2;
    s_d.conv_start = 1'b0;
    s_d.rdata = '0;

    if (rd_i)
    begin
      if (addr_i[sar_adc_pkg::PAGE_HI:sar_adc_pkg::PAGE_LO] == sar_adc_pkg::BUF_PAGE)
        s_d.rdata = s_q.buffer[addr_i[sar_adc_pkg::BUF_IDX_HI:sar_adc_pkg::BUF_IDX_LO]];
      else
      begin
        case (addr_i)
          sar_adc_pkg::ADR_CTL1: s_d.rdata = s_q.c1;
          sar_adc_pkg::ADR_CTL2: s_d.rdata = s_q.c2;
          sar_adc_pkg::ADR_CTL3: s_d.rdata = s_q.c3;
          sar_adc_pkg::ADR_MASK: s_d.rdata = s_q.mask;
          sar_adc_pkg::ADR_CHS: s_d.rdata = s_q.chs;
          sar_adc_pkg::ADR_STAT: s_d.rdata = {{(sar_adc_pkg::DATA_W-1){1'b0}}, s_q.flag};
          default: s_d.rdata = '0;
        endcase
      end
    end

    // Software writes first, so hardware updates below win a same-cycle clash
    if (wr_i)
    begin
      case (addr_i)
        sar_adc_pkg::ADR_CTL1:
          s_d.c1 = sar_adc_pkg::ctl1_t'(wdata_i & sar_adc_pkg::CTL1_WMASK);
        sar_adc_pkg::ADR_CTL2:
        begin
          s_d.c2 = sar_adc_pkg::ctl2_t'(wdata_i & sar_adc_pkg::CTL2_WMASK);
          s_d.c2.fill_half_status = s_q.c2.fill_half_status;
        end
        sar_adc_pkg::ADR_CTL3:
          s_d.c3 = sar_adc_pkg::ctl3_t'(wdata_i & sar_adc_pkg::CTL3_WMASK);
        sar_adc_pkg::ADR_MASK: s_d.mask = wdata_i & sar_adc_pkg::MASK_WMASK;
        sar_adc_pkg::ADR_CHS:
          s_d.chs = sar_adc_pkg::chs_t'(wdata_i & sar_adc_pkg::CHS_WMASK);
        sar_adc_pkg::ADR_STAT:
          if (wdata_i[sar_adc_pkg::FLAG_BIT])
            s_d.flag = 1'b0;
        default: ;
      endcase
    end

    if (!s_q.c1.on)
    begin
      s_d.buffer = '0;
      s_d.ptr = '0;
      s_d.seq = '0;
      s_d.alt_b = 1'b0;
      s_d.c2.fill_half_status = 1'b0;
      s_d.scan_idx = next_scan(s_q.mask, '1);
      s_d.fsm = sar_adc_pkg::ST_IDLE;
    end
    else if (!halt)
    begin
      unique case (s_q.fsm)
        sar_adc_pkg::ST_IDLE:
          if (s_d.c1.sample_enable)
          begin
            s_d.fsm = sar_adc_pkg::ST_SAMPLE;
            s_d.sample_time_cnt = '0;
          end
        sar_adc_pkg::ST_SAMPLE:
        begin
          if (conv_tick && s_q.sample_time_cnt != s_q.c3.auto_sample_time)
            s_d.sample_time_cnt = s_q.sample_time_cnt + 5'h1;
          case (s_q.c1.trigger_source)
            sar_adc_pkg::TRG_SW: trig = !s_d.c1.sample_enable;
            sar_adc_pkg::TRG_PIN: trig = pin_rise;
            sar_adc_pkg::TRG_TIMER: trig = timer_match_i;
            sar_adc_pkg::TRG_AUTO: trig = (s_q.sample_time_cnt == s_q.c3.auto_sample_time);
            default: trig = 1'b0;
          endcase
          if (trig)
          begin
            s_d.c1.sample_enable = 1'b0;
            s_d.c1.done = 1'b0;
            s_d.conv_start = 1'b1;
            s_d.fsm = sar_adc_pkg::ST_CONVERT;
          end
        end
        sar_adc_pkg::ST_CONVERT:
          if (sar_done_i)
          begin
            s_d.buffer[wr_idx] = fmt_word;
            s_d.c1.done = 1'b1;
            if (s_q.c2.alternate_mux_mode)
              s_d.alt_b = ~s_q.alt_b;
            if (s_q.c2.scan_enable && !s_q.alt_b)
              s_d.scan_idx = next_scan(s_q.mask, s_q.scan_idx);
            if (s_q.seq == s_q.c2.interrupt_rate)
            begin
              s_d.flag = 1'b1;
              s_d.seq = '0;
              s_d.ptr = '0;
              s_d.alt_b = 1'b0;
              s_d.scan_idx = next_scan(s_q.mask, '1);
              if (s_q.c2.split_buffer_mode)
                s_d.c2.fill_half_status = ~s_q.c2.fill_half_status;
            end
            else
            begin
              s_d.seq = s_q.seq + 4'h1;
              s_d.ptr = s_q.c2.split_buffer_mode ? {1'b0, 3'(s_q.ptr[2:0] + 3'h1)}
                        : s_q.ptr + 4'h1;
            end
            if (s_q.c1.auto_sample_start)
            begin
              s_d.c1.sample_enable = 1'b1;
              s_d.sample_time_cnt = '0;
              s_d.fsm = sar_adc_pkg::ST_SAMPLE;
            end
            else
              s_d.fsm = sar_adc_pkg::ST_IDLE;
          end
        default: s_d.fsm = sar_adc_pkg::ST_IDLE;
      endcase
    end

    // Input selection for the next sample
    if (s_d.alt_b)
    begin
      s_d.chan = s_d.chs.chsb;
      s_d.neg_sel = s_d.chs.chnb;
    end
    else
    begin
      s_d.chan = s_d.c2.scan_enable ? s_d.scan_idx : s_d.chs.chsa;
      s_d.neg_sel = s_d.chs.chna;
    end
    s_d.vref_pos = !s_d.c2.reference_select[sar_adc_pkg::REF_HI_BIT]
                   && s_d.c2.reference_select[sar_adc_pkg::REF_POS_BIT];
    s_d.vref_neg = !s_d.c2.reference_select[sar_adc_pkg::REF_HI_BIT]
                   && s_d.c2.reference_select[sar_adc_pkg::REF_NEG_BIT];
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign rdata_o = s_q.rdata;
  assign sampling_o = s_q.c1.sample_enable;
  assign conv_start_o = s_q.conv_start;
  assign chan_sel_o = s_q.chan;
  assign neg_sel_o = s_q.neg_sel;
  assign vref_pos_ext_o = s_q.vref_pos;
  assign vref_neg_ext_o = s_q.vref_neg;
  assign conv_tick_o = conv_tick;
  assign conv_irq_o = s_q.flag;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!nrst_i);

  logic run;
  assign run = s_q.c1.on && !halt;

  sw_trigger_a: assert property (
    run && s_q.fsm == sar_adc_pkg::ST_SAMPLE && s_q.c1.trigger_source == sar_adc_pkg::TRG_SW
    && wr_i && addr_i == sar_adc_pkg::ADR_CTL1 && !wdata_i[1] |=> conv_start_o)
    else $error("software clear of sample enable did not start conversion");

  timer_trigger_a: assert property (
    run && s_q.fsm == sar_adc_pkg::ST_SAMPLE && s_q.c1.trigger_source == sar_adc_pkg::TRG_TIMER
    && timer_match_i |=> conv_start_o ##1 !conv_start_o)
    else $error("timer match did not start exactly one conversion");

  pin_trigger_a: assert property (
    run && s_q.fsm == sar_adc_pkg::ST_SAMPLE && s_q.c1.trigger_source == sar_adc_pkg::TRG_PIN
    && !pin_rise |=> !conv_start_o)
    else $error("conversion started without a pin edge");

  auto_trigger_a: assert property (
    run && s_q.fsm == sar_adc_pkg::ST_SAMPLE && s_q.c1.trigger_source == sar_adc_pkg::TRG_AUTO
    && s_q.sample_time_cnt == s_q.c3.auto_sample_time |=> conv_start_o && !sampling_o)
    else $error("sample counter expiry did not start conversion");

  done_clear_a: assert property (
    conv_start_o |-> !s_q.c1.done && s_q.fsm == sar_adc_pkg::ST_CONVERT)
    else $error("done bit set while a conversion runs");

  done_set_a: assert property (
    run && s_q.fsm == sar_adc_pkg::ST_CONVERT && sar_done_i |=> s_q.c1.done)
    else $error("done bit not set at end of conversion");

  auto_start_a: assert property (
    run && s_q.fsm == sar_adc_pkg::ST_CONVERT && sar_done_i && s_q.c1.auto_sample_start
    |=> sampling_o && s_q.fsm == sar_adc_pkg::ST_SAMPLE)
    else $error("auto start did not resume sampling");

  flag_sticky_a: assert property (
    conv_irq_o && !(wr_i && addr_i == sar_adc_pkg::ADR_STAT) |=> conv_irq_o)
    else $error("interrupt flag dropped without a clear");

  off_clears_a: assert property (
    !s_q.c1.on |=> s_q.ptr == '0 && s_q.seq == '0 && s_q.buffer == '0)
    else $error("buffer state kept while module off");

  idle_hold_a: assert property (
    s_q.c1.on && halt ##1 s_q.c1.on |-> $stable(s_q.fsm) && $stable(s_q.ptr))
    else $error("sequencer moved while halted in idle");

  irq_rate_a: assert property (
    run && s_q.fsm == sar_adc_pkg::ST_CONVERT && sar_done_i && s_q.seq == s_q.c2.interrupt_rate
    |=> conv_irq_o && s_q.ptr == '0 && s_q.seq == '0)
    else $error("interrupt or buffer restart missing at sequence count");

  conv_seen_c: cover property (conv_start_o ##[1:300] s_q.c1.done);
  split_toggle_c: cover property (s_q.c2.split_buffer_mode && $rose(s_q.c2.fill_half_status));
  scan_step_c: cover property (s_q.c2.scan_enable && $changed(s_q.scan_idx) && s_q.c1.on);
  alt_b_c: cover property (s_q.c2.alternate_mux_mode && $rose(s_q.alt_b));
endmodule

// ==== sar_core_model.sv ====
// Behavioural analog core: answers each conversion start after a set delay
`timescale 1ns/1ns
module sar_core_model (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic start_i,
  input wire logic [3:0] delay_i,
  input wire logic [sar_adc_pkg::RES_W-1:0] value_i,
  output logic done_o,
  output logic [sar_adc_pkg::RES_W-1:0] result_o
);
  logic [3:0] cnt_q;
  logic busy_q;

  // Result lines toggle every cycle outside the done pulse, so nothing stale looks valid
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cnt_q <= 4'h0;
      busy_q <= 1'b0;
      done_o <= 1'b0;
      result_o <= '0;
    end
    else
    begin
      done_o <= 1'b0;
      result_o <= ~result_o;
      if (start_i)
      begin
        busy_q <= 1'b1;
        cnt_q <= delay_i;
      end
      else if (busy_q && cnt_q == 4'h0)
      begin
        busy_q <= 1'b0;
        done_o <= 1'b1;
        result_o <= value_i;
      end
      else if (busy_q)
        cnt_q <= cnt_q - 4'h1;
    end
  end
endmodule

// ==== sar_adc_sequencer_tb.sv ====
// Self-checking bench for the converter sequencer
`timescale 1ns/1ns
module sar_adc_sequencer_tb;
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [sar_adc_pkg::ADDR_W-1:0] addr_i = 8'h00;
  logic [sar_adc_pkg::DATA_W-1:0] wdata_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic idle_i = 1'b0;
  logic tmr = 1'b0;
  logic pin = 1'b0;
  logic rc = 1'b0;
  logic [sar_adc_pkg::DATA_W-1:0] rdata_o;
  logic sar_done;
  logic [sar_adc_pkg::RES_W-1:0] sar_res;
  logic [sar_adc_pkg::RES_W-1:0] val = 10'h000;
  logic [3:0] dly = 4'h3;
  logic sampling_o, conv_start_o, neg_sel_o, vpos, vneg, conv_tick_o, conv_irq_o;
  logic [sar_adc_pkg::CHAN_W-1:0] chan_sel_o;
  logic rd_d = 1'b0;
  logic [15:0] expq[$];
  logic [31:0] lfsr = 32'h0001_06B0;
  int n_fail = 0;
  int checks_done = 0;
  int n_start = 0;
  int n_done = 0;
  int n_tick = 0;
  int cyc = 0;

  sar_adc_sequencer uut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .idle_i(idle_i),
    .timer_match_i(tmr), .ext_interrupt_zero_pin_i(pin), .rc_osc_i(rc),
    .sar_done_i(sar_done), .sar_result_i(sar_res), .sampling_o(sampling_o),
    .conv_start_o(conv_start_o), .chan_sel_o(chan_sel_o), .neg_sel_o(neg_sel_o),
    .vref_pos_ext_o(vpos), .vref_neg_ext_o(vneg), .conv_tick_o(conv_tick_o),
    .conv_irq_o(conv_irq_o));

  sar_core_model u_core (.clk_i(ref_clk_i), .nrst_i(nrst_i), .start_i(conv_start_o),
    .delay_i(dly), .value_i(val), .done_o(sar_done), .result_o(sar_res));

  initial forever #50 ref_clk_i = ~ref_clk_i;
  // Free-running private oscillator, unrelated to the system clock
  initial forever #370 rc = ~rc;

  function automatic logic [31:0] step(input logic [31:0] v);
    step = v[0] ? ((v >> 1) ^ 32'h8020_0003) : (v >> 1);
  endfunction

  // Signed codes read the raw value as offset binary
  function automatic logic [15:0] fmt(input logic [1:0] f, input logic [9:0] r);
    logic [9:0] s;
    s = r ^ 10'h200;
    case (f)
      sar_adc_pkg::FMT_UINT: fmt = {6'h00, r};
      sar_adc_pkg::FMT_SINT: fmt = {{6{s[9]}}, s};
      sar_adc_pkg::FMT_FRAC: fmt = {r, 6'h00};
      default: fmt = {s, 6'h00};
    endcase
  endfunction

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge ref_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    expq.push_back(e);
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
  endtask

  task automatic wait_start(input int s0, input bit want);
    for (int i = 0; i < 40 && n_start == s0; i++)
      @(posedge ref_clk_i);
    check({15'h0000, n_start != s0}, {15'h0000, want});
  endtask

  task automatic conv(input logic [2:0] trg, input logic [1:0] f);
    int s0;
    logic [15:0] c1;
    logic [9:0] r;
    lfsr = step(lfsr);
    r = lfsr[9:0];
    val <= r;
    dly <= lfsr[13:10];
    c1 = {1'b1, 5'h00, f, trg, 5'h02};
    wr(sar_adc_pkg::ADR_STAT, 16'h0001);
    s0 = n_start;
    wr(sar_adc_pkg::ADR_CTL1, c1);
    if (trg == sar_adc_pkg::TRG_SW)
      wr(sar_adc_pkg::ADR_CTL1, c1 & 16'hFFFD);
    @(posedge ref_clk_i);
    tmr <= (trg == sar_adc_pkg::TRG_TIMER);
    pin <= (trg == sar_adc_pkg::TRG_PIN);
    @(posedge ref_clk_i);
    tmr <= 1'b0;
    wait_start(s0, 1'b1);
    for (int i = 0; i < 40 && conv_irq_o !== 1'b1; i++)
      @(posedge ref_clk_i);
    pin <= 1'b0;
    rd(8'h40, fmt(f, r));
    rd(sar_adc_pkg::ADR_STAT, 16'h0001);
    rd(sar_adc_pkg::ADR_CTL1, {c1[15:2], 2'b01});
  endtask

  always @(posedge ref_clk_i)
  begin
    rd_d <= rd_i;
    cyc <= cyc + 1;
    if (conv_start_o === 1'b1)
      n_start <= n_start + 1;
    if (sar_done === 1'b1)
      n_done <= n_done + 1;
    if (conv_tick_o === 1'b1)
      n_tick <= n_tick + 1;
    if (rd_d === 1'b1 && expq.size() > 0)
      check(rdata_o, expq.pop_front());
    if (cyc == 20000)
    begin
      n_fail++;
      print_verdict();
    end
  end

  initial
  begin
    int s0;
    repeat (4) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    for (int i = 0; i < 7; i++)
      rd(8'(i * 4), 16'h0000);
    wr(sar_adc_pkg::ADR_CTL3, 16'hFFFF);
    rd(sar_adc_pkg::ADR_CTL3, 16'h9FFF);
    wr(sar_adc_pkg::ADR_CTL3, 16'h0000);
    for (int c = 0; c < 8; c++)
    begin
      wr(sar_adc_pkg::ADR_CTL2, {3'(c), 13'h0000});
      repeat (2) @(posedge ref_clk_i);
      check({14'h0000, vpos, vneg}, {14'h0000, c == 1 || c == 3, c == 2 || c == 3});
    end
    wr(sar_adc_pkg::ADR_CTL2, 16'h0000);
    for (int f = 0; f < 4; f++)
      conv(sar_adc_pkg::TRG_AUTO, 2'(f));
    conv(sar_adc_pkg::TRG_SW, 2'h0);
    conv(sar_adc_pkg::TRG_PIN, 2'h1);
    conv(sar_adc_pkg::TRG_TIMER, 2'h2);
    wr(sar_adc_pkg::ADR_CTL2, 16'h0004);
    wr(sar_adc_pkg::ADR_STAT, 16'h0001);
    s0 = n_done;
    wr(sar_adc_pkg::ADR_CTL1, 16'h80E6);
    for (int i = 0; i < 80 && conv_irq_o !== 1'b1; i++)
      @(posedge ref_clk_i);
    check(16'(n_done - s0), 16'h0002);
    wr(sar_adc_pkg::ADR_CTL1, 16'h8000);
    rd(8'h44, fmt(2'h0, val));
    wr(sar_adc_pkg::ADR_CTL2, 16'h0000);
    repeat (20) @(posedge ref_clk_i);
    s0 = n_start;
    wr(sar_adc_pkg::ADR_CTL1, 16'h8062);
    wait_start(s0, 1'b0);
    check({15'h0000, sampling_o}, 16'h0001);
    wr(sar_adc_pkg::ADR_CTL3, 16'h0003);
    repeat (2) @(posedge ref_clk_i);
    s0 = n_tick;
    repeat (40) @(posedge ref_clk_i);
    check(16'(n_tick - s0), 16'h000A);
    wr(sar_adc_pkg::ADR_CTL3, 16'h0000);
    idle_i <= 1'b1;
    s0 = n_start;
    wr(sar_adc_pkg::ADR_CTL1, 16'hA0E2);
    wait_start(s0, 1'b0);
    idle_i <= 1'b0;
    wait_start(s0, 1'b1);
    repeat (30) @(posedge ref_clk_i);
    wr(sar_adc_pkg::ADR_CTL1, 16'h0000);
    rd(8'h40, 16'h0000);
    wr(sar_adc_pkg::ADR_CHS, 16'h8A05);
    wr(sar_adc_pkg::ADR_MASK, 16'h0018);
    wr(sar_adc_pkg::ADR_CTL2, 16'h0400);
    repeat (2) @(posedge ref_clk_i);
    check({11'h000, neg_sel_o, chan_sel_o}, 16'h0003);
    wr(sar_adc_pkg::ADR_CTL2, 16'h0000);
    repeat (2) @(posedge ref_clk_i);
    check({11'h000, neg_sel_o, chan_sel_o}, 16'h0005);
    repeat (3) @(posedge ref_clk_i);
    print_verdict();
  end
endmodule
